// file: include/omg_pkg.sv
// shared constants for the overcurrent measurement gating block
`default_nettype none
package omg_pkg;
  localparam int          OMG_SW          = 16;
  localparam int          OMG_FW          = 16;
  // frequency is handled in units of 0.1 Hz
  localparam logic [15:0] OMG_FNOM_RST    = 16'h01f4;
  localparam logic [15:0] OMG_F_LOW       = 16'h0032;
  localparam logic [15:0] OMG_F_HIGH      = 16'h02bc;
  localparam logic [15:0] OMG_F_HYST      = 16'h000a;
  // deviation band, percent of nominal
  localparam int          OMG_BAND_PCT    = 10;
  // voltage magnitude minimum, in sample units of 0.1 V
  localparam logic [15:0] OMG_VMIN        = 16'h0064;
  localparam int          OMG_SETTLE_CYC  = 2;
  localparam int          OMG_DFT_PER_CYC = 4;
  localparam int          OMG_CNT_W       = 20;
  localparam logic [19:0] OMG_CNT_RST     = 20'h00000;
  // measuring method encodings
  localparam logic [1:0]  OMG_METH_FUND   = 2'h0;
  localparam logic [1:0]  OMG_METH_RMS    = 2'h1;
  localparam logic [1:0]  OMG_METH_NEG    = 2'h2;
  typedef enum logic [2:0] {
    OMG_S_RATED  = 3'b001,
    OMG_S_SETTLE = 3'b010,
    OMG_S_MEAS   = 3'b100
  } omg_state_t;
endpackage : omg_pkg
`default_nettype wire

// file: rtl/omg_cycle_timer.sv
// cycle period measurement from rising zero crossings of one voltage
`default_nettype none
module omg_cycle_timer
  import omg_pkg::*;
#(
  parameter int SW = OMG_SW,
  parameter int CW = OMG_CNT_W
) (
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // sample stream
  input  wire logic          i_valid,
  input  wire logic [SW-1:0] i_sample,
  // rising crossing strobe and measured period in samples
  output logic               o_cross,
  output logic [CW-1:0]      o_period
);
  logic          sign_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sign_reg <= 1'b0;
      cnt_reg  <= OMG_CNT_RST;
      o_period <= OMG_CNT_RST;
      o_cross  <= 1'b0;
    end else begin
      o_cross <= 1'b0;
      if (i_valid) begin
        sign_reg <= i_sample[SW-1];
        // negative to non-negative is one rising crossing
        if (sign_reg && !i_sample[SW-1]) begin
          o_period <= cnt_reg;
          cnt_reg  <= CW'(1);
          o_cross  <= 1'b1;
        end else if (cnt_reg != {CW{1'b1}}) begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
    end
  end
endmodule : omg_cycle_timer
`default_nettype wire

// file: rtl/omg_gating.sv
// frequency supervision, inrush blocking and directional reference selection
`default_nettype none
module omg_gating
  import omg_pkg::*;
#(
  parameter int SW          = OMG_SW,
  parameter int CW          = OMG_CNT_W,
  parameter int DFT_PER_CYC = OMG_DFT_PER_CYC,
  parameter int SETTLE_CYC  = OMG_SETTLE_CYC
) (
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // sample stream, one strobe per sample set
  input  wire logic          i_sample_valid,
  input  wire logic [31:0]   i_sample_rate,
  input  wire logic [SW-1:0] i_volt_one,
  input  wire logic [SW-1:0] i_volt_two,
  input  wire logic [SW-1:0] i_volt_three,
  input  wire logic [SW-1:0] i_volt_four,
  input  wire logic [SW-1:0] i_volt_mag,
  // precomputed magnitudes per phase, and the negative sequence current
  input  wire logic [SW-1:0] i_fund_one,
  input  wire logic [SW-1:0] i_fund_two,
  input  wire logic [SW-1:0] i_fund_three,
  input  wire logic [SW-1:0] i_harm2_one,
  input  wire logic [SW-1:0] i_harm2_two,
  input  wire logic [SW-1:0] i_harm2_three,
  input  wire logic [SW-1:0] i_rms_one,
  input  wire logic [SW-1:0] i_rms_two,
  input  wire logic [SW-1:0] i_rms_three,
  input  wire logic [SW-1:0] i_negative_sequence_current,
  // line voltages for direction reference
  input  wire logic [SW-1:0] i_ref_voltage_two_three,
  input  wire logic [SW-1:0] i_ref_voltage_three_one,
  input  wire logic [SW-1:0] i_ref_voltage_one_two,
  input  wire logic [2:0]    i_ref_memory_valid,
  // configuration
  input  wire logic [15:0]   i_nominal_frequency,
  input  wire logic          i_wide_range_option,
  input  wire logic [7:0]    i_harmonic_ratio_threshold,
  input  wire logic          i_inrush_enable,
  input  wire logic          i_all_phase_block_mode,
  input  wire logic          i_no_ref_trip_undirected,
  input  wire logic          i_non_directional,
  input  wire logic [1:0]    i_measuring_method,
  // frequency supervision outputs
  output logic [15:0]        o_frequency,
  output logic               o_freq_measured,
  output logic               o_wide_mode,
  output logic               o_dft_block,
  output logic               o_rms_active,
  output logic               o_dft_update,
  output logic               o_rms_update,
  // inrush outputs
  output logic               o_inrush_alarm,
  output logic [2:0]         o_inrush_block,
  output logic               o_inrush_event,
  // direction and element outputs
  output logic [SW-1:0]      o_ref_voltage_one,
  output logic [SW-1:0]      o_ref_voltage_two,
  output logic [SW-1:0]      o_ref_voltage_three,
  output logic [2:0]         o_dir_enable,
  output logic [2:0]         o_dir_block,
  output logic [SW-1:0]      o_meas_one,
  output logic [SW-1:0]      o_meas_two,
  output logic [SW-1:0]      o_meas_three,
  output logic               o_element_block
);
  omg_state_t    state_reg;
  logic [3:0]    cross_v;
  logic [CW-1:0] period_v [4];
  logic [CW-1:0] period_reg;
  logic [CW-1:0] since_reg;
  logic [CW-1:0] slot_reg;
  logic [7:0]    settle_reg;
  logic          off_band_reg;
  logic          below_reg;
  logic [15:0]   freq_use;
  logic [15:0]   band;
  logic          off_band;
  logic          ch_cross;
  logic [2:0]    harm_hit;
  logic [2:0]    ref_ok;
  logic          block_prev_reg;
  logic [SW-1:0] fund_a   [3];
  logic [SW-1:0] harm_a   [3];
  logic [SW-1:0] rms_a    [3];
  logic [SW-1:0] lref_a   [3];
  logic [SW-1:0] volt_a   [4];

  assign volt_a = '{i_volt_one, i_volt_two, i_volt_three, i_volt_four};
  assign fund_a = '{i_fund_one, i_fund_two, i_fund_three};
  assign harm_a = '{i_harm2_one, i_harm2_two, i_harm2_three};
  assign rms_a  = '{i_rms_one, i_rms_two, i_rms_three};
  // each phase current pairs with the line voltage it does not share
  assign lref_a = '{i_ref_voltage_two_three, i_ref_voltage_three_one,
                    i_ref_voltage_one_two};

  // one period timer per voltage input
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_timer
      omg_cycle_timer #(
        .SW (SW),
        .CW (CW)
      ) u_timer (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_valid   (i_sample_valid),
        .i_sample  (volt_a[g]),
        .o_cross   (cross_v[g]),
        .o_period  (period_v[g])
      );
    end
  endgenerate

  function automatic logic [SW-1:0] omg_select(input logic [1:0]    meth,
                                               input logic [SW-1:0] fund,
                                               input logic [SW-1:0] rms,
                                               input logic [SW-1:0] neg);
    unique case (meth)
      OMG_METH_RMS: omg_select = rms;
      OMG_METH_NEG: omg_select = neg;
      default:      omg_select = fund;
    endcase
  endfunction : omg_select

  // first channel with a crossing supplies the period; voltage gate applies
  always_comb begin
    ch_cross = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (cross_v[k]) begin
        ch_cross = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      period_reg <= OMG_CNT_RST;
      since_reg  <= OMG_CNT_RST;
    end else begin
      if (ch_cross && i_volt_mag > OMG_VMIN) begin
        period_reg <= cross_v[0] ? period_v[0] : cross_v[1] ? period_v[1] :
                      cross_v[2] ? period_v[2] : period_v[3];
        since_reg  <= OMG_CNT_RST;
      end else if (i_sample_valid && since_reg != {CW{1'b1}}) begin
        since_reg <= since_reg + CW'(1);
      end
    end
  end

  // measured frequency in 0.1 Hz: rate*10/period; rated when unmeasured
  logic        meas_ok;
  logic [47:0] quot;
  assign meas_ok  = (period_reg != '0) && (i_volt_mag > OMG_VMIN) &&
                    (since_reg < (period_reg << 2));
  assign quot     = (48'(i_sample_rate) * 48'd10) / 48'(period_reg | CW'(!meas_ok));
  assign freq_use = meas_ok ? quot[15:0] : i_nominal_frequency;
  assign band     = 16'((32'(i_nominal_frequency) * OMG_BAND_PCT) / 100);
  assign off_band = (freq_use > i_nominal_frequency + band) ||
                    (freq_use + band < i_nominal_frequency);

  // below-range flag with hysteresis so low frequency does not chatter
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      below_reg <= 1'b0;
    end else if (i_sample_valid) begin
      if (freq_use < OMG_F_LOW) begin
        below_reg <= 1'b1;
      end else if (freq_use >= OMG_F_LOW + OMG_F_HYST) begin
        below_reg <= 1'b0;
      end
    end
  end

  // rated / settling / measured sequencing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg  <= OMG_S_RATED;
      settle_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        OMG_S_RATED: begin
          if (meas_ok) begin
            state_reg  <= OMG_S_SETTLE;
            settle_reg <= 8'h00;
          end
        end
        OMG_S_SETTLE: begin
          if (!meas_ok) begin
            state_reg <= OMG_S_RATED;
          end else if (ch_cross) begin
            // wide mode waits out the rms settling time
            if (settle_reg == 8'(SETTLE_CYC - 1)) begin
              state_reg <= OMG_S_MEAS;
            end else begin
              settle_reg <= settle_reg + 8'h01;
            end
          end
        end
        OMG_S_MEAS: begin
          if (!meas_ok) begin
            state_reg <= OMG_S_RATED;
          end
        end
        default: state_reg <= OMG_S_RATED;
      endcase
    end
  end

  // registered supervision flags, refreshed on every update
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frequency     <= OMG_FNOM_RST;
      o_freq_measured <= 1'b0;
      o_wide_mode     <= 1'b0;
      o_dft_block     <= 1'b0;
      o_rms_active    <= 1'b1;
      off_band_reg    <= 1'b0;
    end else if (i_sample_valid) begin
      o_frequency     <= freq_use;
      o_freq_measured <= meas_ok;
      off_band_reg    <= off_band;
      o_wide_mode     <= (state_reg == OMG_S_MEAS) && off_band;
      o_dft_block     <= i_wide_range_option && (state_reg == OMG_S_MEAS) &&
                         off_band;
      o_rms_active    <= !below_reg && freq_use <= OMG_F_HIGH;
    end
  end

  // update strobes: transform several per cycle; rms once per cycle off band
  logic [CW-1:0] slot_len;
  assign slot_len = (period_reg == '0) ? CW'(1) :
                    CW'(period_reg / CW'(DFT_PER_CYC)) | CW'(1);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_reg     <= OMG_CNT_RST;
      o_dft_update <= 1'b0;
      o_rms_update <= 1'b0;
    end else begin
      o_dft_update <= 1'b0;
      o_rms_update <= 1'b0;
      if (i_sample_valid) begin
        if (slot_reg + CW'(1) >= slot_len) begin
          slot_reg     <= OMG_CNT_RST;
          o_dft_update <= !o_dft_block;
          o_rms_update <= !off_band_reg;
        end else begin
          slot_reg <= slot_reg + CW'(1);
        end
        if (off_band_reg && ch_cross) begin
          o_rms_update <= 1'b1;
        end
      end
    end
  end

  // inrush: harm2*100 > threshold*fund, threshold in percent
  generate
    for (g = 0; g < 3; g++) begin : g_harm
      assign harm_hit[g] = (32'(harm_a[g]) * 32'd100) >
                           (32'(i_harmonic_ratio_threshold) * 32'(fund_a[g]));
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_inrush_alarm <= 1'b0;
      o_inrush_block <= 3'h0;
      o_inrush_event <= 1'b0;
      block_prev_reg <= 1'b0;
    end else begin
      o_inrush_event <= 1'b0;
      if (i_sample_valid) begin
        o_inrush_alarm <= i_inrush_enable && (|harm_hit);
        if (!i_inrush_enable) begin
          o_inrush_block <= 3'h0;
        end else if (i_all_phase_block_mode) begin
          o_inrush_block <= {3{|harm_hit}};
        end else begin
          o_inrush_block <= harm_hit;
        end
        block_prev_reg <= i_inrush_enable && (|harm_hit);
        // one pulse per onset for the event recorder
        o_inrush_event <= i_inrush_enable && (|harm_hit) && !block_prev_reg;
      end
    end
  end

  // direction reference and element measurement, per phase
  generate
    for (g = 0; g < 3; g++) begin : g_dir
      assign ref_ok[g] = (lref_a[g] > OMG_VMIN) || i_ref_memory_valid[g];
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ref_voltage_one   <= '0;
      o_ref_voltage_two   <= '0;
      o_ref_voltage_three <= '0;
      o_dir_enable        <= 3'h0;
      o_dir_block         <= 3'h0;
      o_meas_one          <= '0;
      o_meas_two          <= '0;
      o_meas_three        <= '0;
      o_element_block     <= 1'b0;
    end else if (i_sample_valid) begin
      o_ref_voltage_one   <= lref_a[0];
      o_ref_voltage_two   <= lref_a[1];
      o_ref_voltage_three <= lref_a[2];
      if (i_non_directional) begin
        o_dir_enable <= 3'h0;
        o_dir_block  <= 3'h0;
      end else begin
        // directional stays off while transforms are unreliable
        o_dir_enable <= ref_ok & {3{!o_dft_block}};
        o_dir_block  <= ~ref_ok & {3{!i_no_ref_trip_undirected}};
      end
      o_meas_one   <= omg_select(i_measuring_method, fund_a[0], rms_a[0],
                                 i_negative_sequence_current);
      o_meas_two   <= omg_select(i_measuring_method, fund_a[1], rms_a[1],
                                 i_negative_sequence_current);
      o_meas_three <= omg_select(i_measuring_method, fund_a[2], rms_a[2],
                                 i_negative_sequence_current);
      o_element_block <= (i_measuring_method == OMG_METH_RMS) ? !o_rms_active :
                         o_dft_block;
    end
  end
endmodule : omg_gating
`default_nettype wire

// file: testbench/omg_gating_properties.sv
// concurrent checks on the gating block ports
`default_nettype none
module omg_gating_checker
  import omg_pkg::*;
#(
  parameter int SW = OMG_SW
) (
  // clock, reset and inputs
  input wire logic          i_ref_clk,
  input wire logic          i_rst,
  input wire logic          i_sample_valid,
  input wire logic [SW-1:0] i_fund_two,
  input wire logic [SW-1:0] i_harm2_two,
  input wire logic [SW-1:0] i_rms_one,
  input wire logic [SW-1:0] i_ref_voltage_two_three,
  input wire logic [15:0]   i_nominal_frequency,
  input wire logic          i_wide_range_option,
  input wire logic [7:0]    i_harmonic_ratio_threshold,
  input wire logic          i_inrush_enable,
  input wire logic          i_all_phase_block_mode,
  input wire logic          i_non_directional,
  input wire logic [1:0]    i_measuring_method,
  // outputs
  input wire logic [15:0]   o_frequency,
  input wire logic          o_freq_measured,
  input wire logic          o_dft_block,
  input wire logic          o_rms_active,
  input wire logic          o_inrush_alarm,
  input wire logic [2:0]    o_inrush_block,
  input wire logic          o_inrush_event,
  input wire logic [SW-1:0] o_ref_voltage_one,
  input wire logic [2:0]    o_dir_enable,
  input wire logic [2:0]    o_dir_block,
  input wire logic [SW-1:0] o_meas_one
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // set when the previous edge took a sample out of reset
  logic tk_reg;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) tk_reg <= 1'b0;
    else tk_reg <= i_sample_valid;
  end
  chk_ref_pairing: assert property (
    tk_reg |-> o_ref_voltage_one == $past(i_ref_voltage_two_three))
    else $error("phase one reference voltage mismatch");
  chk_rated_freq: assert property (
    !o_freq_measured |-> o_frequency == i_nominal_frequency)
    else $error("rated frequency not used");
  chk_block_measured: assert property (
    o_dft_block |-> o_freq_measured)
    else $error("transform block without measured frequency");
  chk_option_gate: assert property (
    tk_reg && !$past(i_wide_range_option) |-> !o_dft_block)
    else $error("transform block without wide range option");
  chk_meas_source: assert property (
    tk_reg && $past(i_measuring_method) == OMG_METH_RMS |-> o_meas_one == $past(i_rms_one))
    else $error("rms source not selected");
  chk_nondir_quiet: assert property (
    tk_reg && $past(i_non_directional) |-> o_dir_enable == 3'h0 && o_dir_block == 3'h0)
    else $error("direction used in non directional mode");
  chk_inrush_ratio: assert property (
    tk_reg && $past(i_inrush_enable) && 32'($past(i_harm2_two)) * 100 >
    32'($past(i_harmonic_ratio_threshold)) * 32'($past(i_fund_two)) |-> o_inrush_alarm)
    else $error("inrush alarm missing");
  chk_all_phase: assert property (
    tk_reg && $past(i_all_phase_block_mode) && o_inrush_alarm |-> o_inrush_block == 3'h7)
    else $error("all phase block incomplete");
  chk_event_pulse: assert property (
    o_inrush_event |-> o_inrush_alarm ##1 !o_inrush_event)
    else $error("inrush event not a single pulse");
  cov_alarm: cover property (o_inrush_alarm);
  cov_dft_block: cover property (o_dft_block);
  cov_rms_off: cover property (!o_rms_active);
  cov_dir_block: cover property (o_dir_block != 3'h0);
endmodule : omg_gating_checker
`default_nettype wire

// file: testbench/omg_feeder_model.sv
// feeder model: sample strobe and square wave phase voltage
`default_nettype none
module omg_feeder_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // waveform settings
  input  wire logic [15:0] i_period,
  input  wire logic [15:0] i_mag,
  // measuring inputs
  output logic             o_valid,
  output logic [15:0]      o_volt,
  output logic [15:0]      o_volt_mag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ph_reg;
  // falling edge updates keep samples clear of the sampling edge
  always_ff @(negedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_reg  <= 16'h0000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b1;
      ph_reg  <= (ph_reg + 16'h0001 >= i_period) ? 16'h0000 : ph_reg + 16'h0001;
    end
  end
  // rising crossing when the phase wraps to zero
  assign o_volt     = (ph_reg < (i_period >> 1)) ? 16'h03e8 : 16'hfc18;
  assign o_volt_mag = i_mag;
endmodule : omg_feeder_model
`default_nettype wire

// file: testbench/overcurrent_measurement_gating_tb_top.sv
// top testbench for the measurement gating block
`default_nettype none
module overcurrent_measurement_gating_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0, i_rst = 1'b1;
  logic [15:0] period = 16'h0014, mag = 16'h00c8;
  wire logic i_sample_valid;
  wire logic [15:0] i_volt_one, i_volt_two, i_volt_three, i_volt_four, i_volt_mag;
  logic [31:0] i_sample_rate = 32'h000003e8;
  logic [15:0] i_fund_one = 16'h03e7, i_fund_two = 16'h03e8, i_fund_three = 16'h03ea;
  logic [15:0] i_harm2_one = 16'h0000, i_harm2_two = 16'h0000, i_harm2_three = 16'h0000;
  logic [15:0] i_rms_one = 16'h03f0, i_rms_two = 16'h03f1, i_rms_three = 16'h03f2;
  logic [15:0] i_negative_sequence_current = 16'h0123;
  logic [15:0] i_ref_voltage_two_three = 16'h0111, i_ref_voltage_three_one = 16'h0222;
  logic [15:0] i_ref_voltage_one_two = 16'h0333, i_nominal_frequency = 16'h01f4;
  logic [2:0] i_ref_memory_valid = 3'h0;
  logic [7:0] i_harmonic_ratio_threshold = 8'h0f;
  logic i_wide_range_option = 1'b1, i_inrush_enable = 1'b0, i_all_phase_block_mode = 1'b0;
  logic i_no_ref_trip_undirected = 1'b0, i_non_directional = 1'b0;
  logic [1:0] i_measuring_method = 2'h0;
  logic [15:0] o_frequency, o_ref_voltage_one, o_ref_voltage_two, o_ref_voltage_three;
  logic [15:0] o_meas_one, o_meas_two, o_meas_three;
  logic o_freq_measured, o_wide_mode, o_dft_block, o_rms_active, o_dft_update, o_rms_update;
  logic o_inrush_alarm, o_inrush_event, o_element_block;
  logic [2:0] o_inrush_block, o_dir_enable, o_dir_block;
  int failures = 0, total_checks = 0, n_rms = 0, n_dft = 0, n_evt = 0, cycles = 0;

  always #25 i_ref_clk = ~i_ref_clk;
  // every channel carries the same wave so crossings coincide
  assign i_volt_two   = i_volt_one;
  assign i_volt_three = i_volt_one;
  assign i_volt_four  = i_volt_one;

  omg_feeder_model i_feeder (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_period(period),
    .i_mag(mag), .o_valid(i_sample_valid), .o_volt(i_volt_one), .o_volt_mag(i_volt_mag));
  omg_gating i_dut (.*);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : cyc
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  always @(posedge i_ref_clk) begin
    n_rms += int'(o_rms_update);
    n_dft += int'(o_dft_update);
    n_evt += int'(o_inrush_event);
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    cyc(10);
    i_rst = 1'b0;
    check(o_frequency, 16'h01f4);
    check(16'(o_rms_active), 16'h0001);
    cyc(160);
    check(16'(o_freq_measured), 16'h0001);
    check(o_frequency, 16'h01f4);
    check(16'(o_dft_block), 16'h0000);
    n_rms = 0;
    n_dft = 0;
    cyc(20);
    check(16'(n_rms), 16'h0004);
    check(16'(n_dft), 16'h0004);
    period = 16'h0019;
    cyc(200);
    check(o_frequency, 16'h0190);
    check(16'(o_dft_block), 16'h0001);
    check(16'(o_wide_mode), 16'h0001);
    check(16'(o_rms_active), 16'h0001);
    i_measuring_method = 2'h1;
    cyc(2);
    check(16'(o_element_block), 16'h0000);
    i_measuring_method = 2'h0;
    cyc(2);
    check(16'(o_element_block), 16'h0001);
    n_rms = 0;
    cyc(50);
    check(16'(n_rms), 16'h0002);
    i_wide_range_option = 1'b0;
    cyc(2);
    check(16'(o_dft_block), 16'h0000);
    i_wide_range_option = 1'b1;
    period = 16'h0016;
    cyc(150);
    check(16'(o_dft_block), 16'h0000);
    period = 16'h0017;
    cyc(150);
    check(16'(o_dft_block), 16'h0001);
    mag = 16'h0064;
    cyc(10);
    check(16'(o_freq_measured), 16'h0000);
    check(o_frequency, 16'h01f4);
    check(16'(o_dft_block), 16'h0000);
    mag = 16'h0065;
    cyc(3);
    check(16'(o_dft_block), 16'h0000);
    cyc(150);
    check(16'(o_dft_block), 16'h0001);
    period = 16'h00fa;
    cyc(1500);
    check(16'(o_rms_active), 16'h0000);
    period = 16'h00b4;
    cyc(1000);
    check(16'(o_rms_active), 16'h0000);
    period = 16'h0096;
    cyc(800);
    check(16'(o_rms_active), 16'h0001);
    period = 16'h0014;
    cyc(200);
    for (int m = 0; m < 4; m++) begin
      i_measuring_method = 2'(m);
      cyc(2);
      if (m == 1) begin
        check(o_meas_one, i_rms_one);
        check(o_meas_two, i_rms_two);
        check(o_meas_three, i_rms_three);
      end else if (m == 2) begin
        check(o_meas_one, i_negative_sequence_current);
        check(o_meas_two, i_negative_sequence_current);
        check(o_meas_three, i_negative_sequence_current);
      end else begin
        check(o_meas_one, i_fund_one);
        check(o_meas_two, i_fund_two);
        check(o_meas_three, i_fund_three);
      end
    end
    // trip delays downstream assumed at least 30 ms while inrush blocking is on
    i_inrush_enable = 1'b1;
    i_harm2_two = 16'h0096;
    cyc(3);
    check(16'(o_inrush_alarm), 16'h0000);
    n_evt = 0;
    i_harm2_two = 16'h0097;
    cyc(5);
    check(16'(o_inrush_alarm), 16'h0001);
    check(16'(o_inrush_block), 16'h0002);
    check(16'(n_evt), 16'h0001);
    i_all_phase_block_mode = 1'b1;
    cyc(2);
    check(16'(o_inrush_block), 16'h0007);
    check(o_ref_voltage_one, 16'h0111);
    check(o_ref_voltage_two, 16'h0222);
    check(o_ref_voltage_three, 16'h0333);
    check(16'(o_dir_enable), 16'h0007);
    i_ref_voltage_two_three = 16'h0000;
    cyc(2);
    check(16'(o_dir_block), 16'h0001);
    i_ref_memory_valid = 3'h1;
    cyc(2);
    check(16'(o_dir_block), 16'h0000);
    i_ref_memory_valid = 3'h0;
    i_no_ref_trip_undirected = 1'b1;
    cyc(2);
    check(16'(o_dir_block), 16'h0000);
    i_no_ref_trip_undirected = 1'b0;
    i_non_directional = 1'b1;
    cyc(2);
    check(16'({o_dir_enable, o_dir_block}), 16'h0000);
    end_of_test();
  end
endmodule : overcurrent_measurement_gating_tb_top

bind omg_gating omg_gating_checker #(.SW(SW)) i_chk (.*);
`default_nettype wire
